//--- rtl/atwc_cfg.svh
`ifndef ATWC_CFG_SVH
`define ATWC_CFG_SVH
// byte addresses on the wishbone bus
`define ATWC_WAVE_CTRL_A_OFS 8'hB0
`define ATWC_WAVE_CTRL_B_OFS 8'hB1
`define ATWC_COUNT_OFS 8'hB2
`define ATWC_CMP_A_OFS 8'hB3
`define ATWC_CMP_B_OFS 8'hB4
`define ATWC_ASYNC_STAT_OFS 8'hB6
`define ATWC_GEN_CTRL_OFS 8'hB8
`define ATWC_IRQ_STAT_OFS 8'hBC
`define ATWC_IRQ_MASK_OFS 8'hC0
// field positions
`define ATWC_ACT_A_LSB 6
`define ATWC_ACT_B_LSB 4
`define ATWC_WGM_HI_BIT 3
`define ATWC_EXT_CLK_BIT 6
`define ATWC_ASYNC_SEL_BIT 5
`define ATWC_PRESC_RST_BIT 1
// reset value and counter limits
`define ATWC_REG_RESET 8'h00
`define ATWC_BOTTOM 8'h00
`define ATWC_MAX 8'hFF
// prescaler taps: bit n of the free-running divider pulses every 2^(n+1) ticks
`define ATWC_DIV8_TAP 2
`define ATWC_DIV32_TAP 4
`define ATWC_DIV64_TAP 5
`define ATWC_DIV128_TAP 6
`define ATWC_DIV256_TAP 7
`define ATWC_DIV1024_TAP 9
`endif

//--- rtl/atwc_pkg.sv
package atwc_pkg;
    typedef enum logic [2:0] {
        ATWC_CS_STOP = 3'h0,
        ATWC_CS_DIV1 = 3'h1,
        ATWC_CS_DIV8 = 3'h2,
        ATWC_CS_DIV32 = 3'h3,
        ATWC_CS_DIV64 = 3'h4,
        ATWC_CS_DIV128 = 3'h5,
        ATWC_CS_DIV256 = 3'h6,
        ATWC_CS_DIV1024 = 3'h7
    } atwc_presc_e;
    typedef enum logic [1:0] {
        ATWC_DIR_UP = 2'b01,
        ATWC_DIR_DOWN = 2'b10
    } atwc_dir_e;
    typedef logic [7:0] atwc_byte_t;
endpackage

//--- rtl/atwc_timer.sv
`timescale 1ns/1ps
`include "atwc_cfg.svh"
module atwc_timer
    import atwc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic osc_in_pin_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic compare_out_a_o,
    output logic compare_out_b_o,
    output logic compare_out_a_en_o,
    output logic compare_out_b_en_o,
    output logic osc_pins_detached_o,
    output logic osc_in_buffer_en_o,
    output logic irq_o
);
    // registers
    logic [7:0] wca_q, wca_d;
    logic wgm_hi_q, wgm_hi_d;
    atwc_presc_e cs_q, cs_d;
    logic [7:0] cnt_q, cnt_d;
    logic [7:0] cmpa_q, cmpa_d, cmpb_q, cmpb_d;
    logic [7:0] cmpa_buf_q, cmpa_buf_d, cmpb_buf_q, cmpb_buf_d;
    logic ext_clk_q, ext_clk_d, async_q, async_d;
    logic [2:0] ist_q, ist_d, imsk_q, imsk_d;
    logic [31:0] rdat_q, rdat_d;
    logic ack_q, ack_d;
    logic oa_q, oa_d, ob_q, ob_d;
    logic oea_q, oea_d, oeb_q, oeb_d, det_q, det_d, ibuf_q, ibuf_d, irq_q, irq_d;
    atwc_dir_e dir_q, dir_d;
    logic [9:0] pre_q, pre_d;
    logic blk_q, blk_d;
    logic src_s1_q, src_s2_q, src_s3_q;

    logic wr, rd, src_tick, tick, presc_rst;
    logic [2:0] wgm;
    logic pwm_fast, pwm_pc, use_cmpa_top;
    logic [7:0] top, cmpa_eff, cmpb_eff;
    logic at_top, at_bot, ovf_ev, match_a, match_b, cnt_wr, lower_write;

    assign wr = cyc_i && stb_i && we_i && !ack_q && sel_i[0];
    assign rd = cyc_i && stb_i && !ack_q;
    assign wgm = {wgm_hi_q, wca_q[1:0]};
    assign pwm_fast = (wgm[1:0] == 2'b11);
    assign pwm_pc = (wgm[1:0] == 2'b01);
    assign use_cmpa_top = wgm[2] || (wgm == 3'd2);
    assign top = use_cmpa_top ? cmpa_q : `ATWC_MAX;
    assign at_top = (cnt_q == top);
    assign at_bot = (cnt_q == `ATWC_BOTTOM);
    assign presc_rst = wr && (adr_i == `ATWC_GEN_CTRL_OFS) && dat_i[`ATWC_PRESC_RST_BIT];
    assign cnt_wr = wr && (adr_i == `ATWC_COUNT_OFS);

    // oscillator pin sampled as a synchronous level; with async_q set a rising edge gives one source tick, else every cycle ticks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            src_s1_q <= 1'b0;
            src_s2_q <= 1'b0;
            src_s3_q <= 1'b0;
        end else if (ce_i) begin
            src_s1_q <= osc_in_pin_i;
            src_s2_q <= src_s1_q;
            src_s3_q <= src_s2_q;
        end
    end
    assign src_tick = async_q ? (src_s2_q && !src_s3_q) : 1'b1;

    // prescaled enable selection
    always_comb begin
        case (cs_q)
            ATWC_CS_STOP: tick = 1'b0;
            ATWC_CS_DIV1: tick = src_tick;
            ATWC_CS_DIV8: tick = src_tick && (&pre_q[`ATWC_DIV8_TAP:0]);
            ATWC_CS_DIV32: tick = src_tick && (&pre_q[`ATWC_DIV32_TAP:0]);
            ATWC_CS_DIV64: tick = src_tick && (&pre_q[`ATWC_DIV64_TAP:0]);
            ATWC_CS_DIV128: tick = src_tick && (&pre_q[`ATWC_DIV128_TAP:0]);
            ATWC_CS_DIV256: tick = src_tick && (&pre_q[`ATWC_DIV256_TAP:0]);
            ATWC_CS_DIV1024: tick = src_tick && (&pre_q[`ATWC_DIV1024_TAP:0]);
            default: tick = 1'b0;
        endcase
    end

    // active compare values: direct in non-pwm, buffered otherwise
    assign cmpa_eff = (pwm_fast || pwm_pc) ? cmpa_buf_q : cmpa_q;
    assign cmpb_eff = (pwm_fast || pwm_pc) ? cmpb_buf_q : cmpb_q;
    assign match_a = tick && !blk_q && (cnt_q == cmpa_eff);
    assign match_b = tick && !blk_q && (cnt_q == cmpb_eff);

    // waveform action for one channel; in pwm modes with wgm_hi_q set, is_a allows code 01 toggle
    function automatic logic wave_next(input logic cur, input logic [1:0] act, input logic match,
                                       input logic [7:0] cmp, input logic is_a);
        logic nxt;
        nxt = cur;
        if (!pwm_fast && !pwm_pc) begin
            if (match) begin
                case (act)
                    2'b01: nxt = !cur;
                    2'b10: nxt = 1'b0;
                    2'b11: nxt = 1'b1;
                    default: nxt = cur;
                endcase
            end
        end else if (act == 2'b01) begin
            if (is_a && wgm_hi_q && match) begin
                nxt = !cur;
            end
        end else if (act[1]) begin
            if (pwm_fast) begin
                if (match && !(cmp == top)) begin
                    nxt = act[0];
                end
                if (tick && at_top) begin
                    nxt = !act[0];
                end
            end else begin
                if (match && !(cmp == top)) begin
                    nxt = (dir_q == ATWC_DIR_UP) ? act[0] : !act[0];
                end else if (tick && at_top && cmp == top) begin
                    nxt = !act[0];
                end
            end
        end
        return nxt;
    endfunction

    always_comb begin
        wca_d = wca_q;
        wgm_hi_d = wgm_hi_q;
        cs_d = cs_q;
        cmpa_d = cmpa_q;
        cmpb_d = cmpb_q;
        ext_clk_d = ext_clk_q;
        async_d = async_q;
        imsk_d = imsk_q;
        cnt_d = cnt_q;
        dir_d = dir_q;
        blk_d = blk_q;
        cmpa_buf_d = cmpa_buf_q;
        cmpb_buf_d = cmpb_buf_q;
        pre_d = pre_q;
        ovf_ev = 1'b0;
        lower_write = 1'b0;
        if (src_tick) begin
            pre_d = pre_q + 10'd1;
        end
        if (presc_rst) begin
            pre_d = '0;
        end
        if (tick) begin
            blk_d = 1'b0;
            if (pwm_pc) begin
                if (dir_q == ATWC_DIR_UP) begin
                    if (at_top) begin
                        dir_d = ATWC_DIR_DOWN;
                        cnt_d = cnt_q - 8'd1;
                        cmpa_buf_d = cmpa_q;
                        cmpb_buf_d = cmpb_q;
                    end else begin
                        cnt_d = cnt_q + 8'd1;
                    end
                end else if (at_bot) begin
                    dir_d = ATWC_DIR_UP;
                    cnt_d = cnt_q + 8'd1;
                    ovf_ev = 1'b1;
                end else begin
                    cnt_d = cnt_q - 8'd1;
                end
            end else begin
                dir_d = ATWC_DIR_UP;
                if (at_top && (use_cmpa_top || pwm_fast)) begin
                    cnt_d = `ATWC_BOTTOM;
                end else begin
                    cnt_d = cnt_q + 8'd1;
                end
                if (pwm_fast && at_top) begin
                    cmpa_buf_d = cmpa_q;
                    cmpb_buf_d = cmpb_q;
                end
                if ((wgm == 3'd7) ? at_top : (cnt_q == `ATWC_MAX)) begin
                    ovf_ev = 1'b1;
                end
            end
        end
        if (!pwm_fast && !pwm_pc) begin
            cmpa_buf_d = cmpa_d;
            cmpb_buf_d = cmpb_d;
        end
        if (wr) begin
            case (adr_i)
                `ATWC_WAVE_CTRL_A_OFS: wca_d = {dat_i[7:4], 2'b00, dat_i[1:0]};
                `ATWC_WAVE_CTRL_B_OFS: begin
                    wgm_hi_d = dat_i[`ATWC_WGM_HI_BIT];
                    cs_d = atwc_presc_e'(dat_i[2:0]);
                end
                `ATWC_COUNT_OFS: begin
                    cnt_d = dat_i[7:0];
                    blk_d = 1'b1;
                end
                `ATWC_CMP_A_OFS: cmpa_d = dat_i[7:0];
                `ATWC_CMP_B_OFS: cmpb_d = dat_i[7:0];
                `ATWC_ASYNC_STAT_OFS: begin
                    ext_clk_d = dat_i[`ATWC_EXT_CLK_BIT];
                    async_d = dat_i[`ATWC_ASYNC_SEL_BIT];
                end
                `ATWC_IRQ_MASK_OFS: imsk_d = dat_i[2:0];
                default: lower_write = 1'b0;
            endcase
        end
    end

    // outputs, status, bus answer
    always_comb begin
        oa_d = oa_q;
        ob_d = ob_q;
        if (!cnt_wr) begin
            oa_d = wave_next(oa_q, wca_q[7:6], match_a, cmpa_eff, 1'b1);
            ob_d = wave_next(ob_q, wca_q[5:4], match_b, cmpb_eff, 1'b0);
        end
        oea_d = |wca_q[7:6];
        oeb_d = |wca_q[5:4];
        det_d = async_q;
        ibuf_d = async_q && ext_clk_q;
        // sticky events: 0 overflow, 1 match a, 2 match b; set beats clear
        ist_d = ist_q;
        if (wr && adr_i == `ATWC_IRQ_STAT_OFS) begin
            ist_d = ist_q & ~dat_i[2:0];
        end
        ist_d = ist_d | {match_b, match_a, ovf_ev};
        irq_d = |(ist_d & imsk_d);
        ack_d = rd;
        rdat_d = '0;
        if (rd && !we_i) begin
            case (adr_i)
                `ATWC_WAVE_CTRL_A_OFS: rdat_d[7:0] = wca_q & 8'hF3;
                `ATWC_WAVE_CTRL_B_OFS: rdat_d[7:0] = {4'h0, wgm_hi_q, cs_q};
                `ATWC_COUNT_OFS: rdat_d[7:0] = cnt_q;
                `ATWC_CMP_A_OFS: rdat_d[7:0] = cmpa_q;
                `ATWC_CMP_B_OFS: rdat_d[7:0] = cmpb_q;
                `ATWC_ASYNC_STAT_OFS: rdat_d[7:0] = {1'b0, ext_clk_q, async_q, 5'h00};
                `ATWC_IRQ_STAT_OFS: rdat_d[2:0] = ist_q;
                `ATWC_IRQ_MASK_OFS: rdat_d[2:0] = imsk_q;
                default: rdat_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wca_q <= `ATWC_REG_RESET;
            wgm_hi_q <= 1'b0;
            cs_q <= ATWC_CS_STOP;
            cnt_q <= `ATWC_REG_RESET;
            cmpa_q <= `ATWC_REG_RESET;
            cmpb_q <= `ATWC_REG_RESET;
            cmpa_buf_q <= `ATWC_REG_RESET;
            cmpb_buf_q <= `ATWC_REG_RESET;
            ext_clk_q <= 1'b0;
            async_q <= 1'b0;
            ist_q <= 3'h0;
            imsk_q <= 3'h0;
            rdat_q <= 32'h0;
            ack_q <= 1'b0;
            oa_q <= 1'b0;
            ob_q <= 1'b0;
            oea_q <= 1'b0;
            oeb_q <= 1'b0;
            det_q <= 1'b0;
            ibuf_q <= 1'b0;
            irq_q <= 1'b0;
            dir_q <= ATWC_DIR_UP;
            pre_q <= 10'h000;
            blk_q <= 1'b0;
        end else if (ce_i) begin
            wca_q <= wca_d;
            wgm_hi_q <= wgm_hi_d;
            cs_q <= cs_d;
            cnt_q <= cnt_d;
            cmpa_q <= cmpa_d;
            cmpb_q <= cmpb_d;
            cmpa_buf_q <= cmpa_buf_d;
            cmpb_buf_q <= cmpb_buf_d;
            ext_clk_q <= ext_clk_d;
            async_q <= async_d;
            ist_q <= ist_d;
            imsk_q <= imsk_d;
            rdat_q <= rdat_d;
            ack_q <= ack_d;
            oa_q <= oa_d;
            ob_q <= ob_d;
            oea_q <= oea_d;
            oeb_q <= oeb_d;
            det_q <= det_d;
            ibuf_q <= ibuf_d;
            irq_q <= irq_d;
            dir_q <= dir_d;
            pre_q <= pre_d;
            blk_q <= blk_d;
        end
    end

    assign dat_o = rdat_q;
    assign ack_o = ack_q;
    assign compare_out_a_o = oa_q;
    assign compare_out_b_o = ob_q;
    assign compare_out_a_en_o = oea_q;
    assign compare_out_b_en_o = oeb_q;
    assign osc_pins_detached_o = det_q;
    assign osc_in_buffer_en_o = ibuf_q;
    assign irq_o = irq_q;
endmodule

//--- sim/atwc_timer_assertions.sv
`timescale 1ns/1ps
`include "atwc_cfg.svh"
module atwc_timer_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic compare_out_a_o,
    input wire logic compare_out_b_o,
    input wire logic compare_out_a_en_o,
    input wire logic osc_pins_detached_o,
    input wire logic osc_in_buffer_en_o,
    input wire logic irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic wr0;
    logic [1:0] act_q;
    logic [1:0] asy_q;
    assign take = cyc_i && stb_i && !ack_o && ce_i;
    assign wr0 = take && we_i && sel_i[0];
    // last written action and async bits, to judge the registered outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            act_q <= 2'b00;
            asy_q <= 2'b00;
        end else begin
            if (wr0 && adr_i == `ATWC_WAVE_CTRL_A_OFS)
                act_q <= dat_i[7:6];
            if (wr0 && adr_i == `ATWC_ASYNC_STAT_OFS)
                asy_q <= dat_i[6:5];
        end
    end
    ack_resp_a: assert property (take |=> ack_o) else $error("no ack one cycle after request");
    ack_pulse_a: assert property (ack_o && ce_i |=> !ack_o) else $error("ack longer than one cycle");
    reset_quiet_a: assert property ($fell(rst_i) |-> !ack_o && !irq_o && !compare_out_a_o && !osc_pins_detached_o)
        else $error("output high after reset");
    ctrl_rsvd_a: assert property (ack_o && !we_i && adr_i == `ATWC_WAVE_CTRL_A_OFS |-> dat_o[3:2] == 2'b00)
        else $error("reserved control bits read nonzero");
    pin_detach_a: assert property (wr0 && adr_i == `ATWC_ASYNC_STAT_OFS |-> ##2 osc_pins_detached_o == asy_q[0])
        else $error("oscillator pins not detached");
    ext_buf_a: assert property (wr0 && adr_i == `ATWC_ASYNC_STAT_OFS |-> ##[1:2] osc_in_buffer_en_o == &asy_q)
        else $error("external clock buffer wrong");
    act_en_a: assert property (wr0 && adr_i == `ATWC_WAVE_CTRL_A_OFS |-> ##[1:2] compare_out_a_en_o == |act_q)
        else $error("pin takeover wrong");
    freeze_hold_a: assert property (!ce_i |=> $stable({compare_out_a_o, compare_out_b_o, irq_o, ack_o}))
        else $error("state moved while frozen");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(wr0))
        else $error("interrupt dropped without a write");
endmodule
bind atwc_timer atwc_timer_assertions i_chk (.*);

//--- sim/atwc_osc_model.sv
`timescale 1ns/1ps
module atwc_osc_model #(
    parameter int HALF = 8
) (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic [1:0] en_i,
    input wire logic [1:0] out_i,
    input wire logic [1:0] dir_i,
    output logic osc_o = 1'b0,
    output logic [1:0] pad_o
);
    int cnt = 0;
    // gated external clock stands low outside bursts
    always @(posedge clk_i) begin
        cnt <= run_i ? (cnt + 1) % HALF : 0;
        if (!run_i)
            osc_o <= 1'b0;
        else if (cnt == HALF - 1)
            osc_o <= !osc_o;
    end
    // driver only with direction set, pull-up otherwise
    assign pad_o = (en_i & dir_i & out_i) | ~(en_i & dir_i);
endmodule

//--- sim/async_timer_waveform_control_test.sv
`timescale 1ns/1ps
`include "atwc_cfg.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; $display("mismatch %s exp %0h got %0h", n, e, g); end end
module async_timer_waveform_control_test;
    import atwc_pkg::*;
    localparam logic [7:0] ra = `ATWC_WAVE_CTRL_A_OFS, rb = `ATWC_WAVE_CTRL_B_OFS, rc = `ATWC_COUNT_OFS;
    localparam logic [7:0] rca = `ATWC_CMP_A_OFS, rcb = `ATWC_CMP_B_OFS, ras = `ATWC_ASYNC_STAT_OFS;
    localparam logic [7:0] rgc = `ATWC_GEN_CTRL_OFS, ris = `ATWC_IRQ_STAT_OFS, rim = `ATWC_IRQ_MASK_OFS;
    logic clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, osc_in_pin_i, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [7:0] adr_i = 8'h00, rv, r2, d;
    logic [3:0] sel_i = 4'hF;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic ack_o, compare_out_a_o, compare_out_b_o, compare_out_a_en_o, compare_out_b_en_o;
    logic osc_pins_detached_o, osc_in_buffer_en_o, irq_o, run = 1'b0, pa;
    logic [1:0] pad;
    logic [7:0] regs [7] = '{8'hB0, 8'hB1, 8'hB2, 8'hB3, 8'hB4, 8'hB6, 8'hA0};
    int err_total = 0, checks = 0, tg;
    always #4 clk_i = !clk_i;
    atwc_timer i_dut (.*);
    atwc_osc_model i_osc (.clk_i(clk_i), .run_i(run), .en_i({compare_out_b_en_o, compare_out_a_en_o}),
        .out_i({compare_out_b_o, compare_out_a_o}), .dir_i(2'b11), .osc_o(osc_in_pin_i), .pad_o(pad));
    function automatic int dv(input int cs);
        return cs == 0 ? 10 : cs == 1 ? 1 : cs == 2 ? 8 : cs == 7 ? 1024 : 1 << (cs + 2);
    endfunction
    // about twenty ticks expected, bus overhead widens the window
    function automatic logic inw(input int cs, input logic [7:0] v);
        return cs == 0 ? v == 8'h00 : v >= 8'd18 && v <= 8'd24;
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] x, output logic [7:0] y);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, x};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 40);
        if (n >= 40) begin
            err_total++;
            conclude();
        end
        y = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] y;
        wb(1'b1, a, x, y);
    endtask
    task automatic restart(input logic [7:0] w, input logic [7:0] b);
        wr(rb, 8'h00);
        wr(rc, 8'h00);
        wr(ra, w);
        wr(rb, b);
    endtask
    initial begin
        void'($urandom(32'h5E84));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wr(8'hA0, 8'hFF);
        foreach (regs[i]) begin
            wb(1'b0, regs[i], 8'h00, rv);
            `CHK("reset_value", 8'h00, rv)
        end
        repeat (4) begin
            d = 8'($urandom);
            wr(ra, d);
            wb(1'b0, ra, 8'h00, rv);
            `CHK("ctrl_a", d & 8'hF3, rv)
        end
        wr(ra, 8'h00);
        `CHK("en_off", 1'b0, compare_out_a_en_o)
        $display("end registers");
        for (int cs = 0; cs < 8; cs++) begin
            wr(rb, 8'h00);
            wr(rc, 8'h00);
            wr(rgc, 8'h02);
            wr(rb, cs[7:0]);
            repeat (dv(cs) * 20) @(posedge clk_i);
            wb(1'b0, rc, 8'h00, rv);
            `CHK("presc_count", 1'b1, inw(cs, rv))
        end
        $display("end prescaler");
        wr(rb, 8'h00);
        wr(ras, 8'h60);
        restart(8'h00, 8'h01);
        `CHK("detach", 1'b1, osc_pins_detached_o)
        `CHK("ext_buf", 1'b1, osc_in_buffer_en_o)
        run <= 1'b1;
        repeat (160) @(posedge clk_i);
        run <= 1'b0;
        wb(1'b0, rc, 8'h00, rv);
        `CHK("async_count", 1'b1, rv >= 8'd8 && rv <= 8'd11)
        repeat (50) @(posedge clk_i);
        wb(1'b0, rc, 8'h00, r2);
        `CHK("async_hold", rv, r2)
        wr(ras, 8'h00);
        $display("end async");
        wr(rca, 8'($urandom_range(8'h60, 8'h20)));
        wr(rcb, 8'($urandom_range(8'h60, 8'h20)));
        for (int c = 3; c > 0; c--) begin
            restart({c[1:0], c[1:0], 4'h0}, 8'h01);
            repeat (128) @(posedge clk_i);
            `CHK("non_pwm_a", c != 2, compare_out_a_o)
            `CHK("non_pwm_b", c != 2, compare_out_b_o)
            `CHK("en_on", 1'b1, compare_out_a_en_o)
            `CHK("en_on_b", 1'b1, compare_out_b_en_o)
            `CHK("pad_a", c != 2, pad[0])
        end
        wr(rca, 8'h80);
        wr(rcb, 8'hFF);
        for (int c = 2; c < 4; c++) begin
            restart({c[1:0], c[1:0], 4'h3}, 8'h01);
            repeat (192) @(posedge clk_i);
            `CHK("fast_a_up", c == 3, compare_out_a_o)
            repeat (128) @(posedge clk_i);
            `CHK("fast_a_wrap", c == 2, compare_out_a_o)
            `CHK("fast_b_top", c == 2, compare_out_b_o)
        end
        wr(ra, 8'h00);
        wr(rca, 8'h40);
        wr(rcb, 8'h40);
        for (int c = 2; c < 4; c++) begin
            restart({c[1:0], c[1:0], 4'h1}, 8'h01);
            repeat (128) @(posedge clk_i);
            `CHK("phase_a_up", c == 3, compare_out_a_o)
            `CHK("phase_b_up", c == 3, compare_out_b_o)
            repeat (352) @(posedge clk_i);
            `CHK("phase_a_down", c == 2, compare_out_a_o)
            `CHK("phase_b_down", c == 2, compare_out_b_o)
        end
        $display("end waveforms");
        wr(ra, 8'h00);
        wr(rca, 8'h20);
        wr(rim, 8'h01);
        restart(8'h02, 8'h01);
        wr(ris, 8'h07);
        repeat (4) begin
            repeat ($urandom_range(60, 5)) @(posedge clk_i);
            wb(1'b0, rc, 8'h00, rv);
            `CHK("ctc_top", 1'b1, rv <= 8'h20)
        end
        wb(1'b0, ris, 8'h00, rv);
        `CHK("ctc_ovf", 1'b0, rv[0])
        `CHK("irq_off", 1'b0, irq_o)
        restart(8'h03, 8'h09);
        ce_i <= 1'b0;
        repeat (30) @(posedge clk_i);
        ce_i <= 1'b1;
        repeat (60) @(posedge clk_i);
        wb(1'b0, ris, 8'h00, rv);
        `CHK("top_ovf", 1'b1, rv[0])
        `CHK("irq_on", 1'b1, irq_o)
        wr(rim, 8'h00);
        `CHK("irq_masked", 1'b0, irq_o)
        wr(rim, 8'h01);
        wr(rb, 8'h00);
        wr(ris, 8'h01);
        `CHK("irq_cleared", 1'b0, irq_o)
        $display("end interrupts");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, rim, 8'h00, rv);
        `CHK("mask_reset", 8'h00, rv)
        $display("end second reset");
        wr(rca, 8'h10);
        wr(rcb, 8'h10);
        restart(8'h61, 8'h09);
        tg = 0;
        pa = compare_out_a_o;
        repeat (320) begin
            @(posedge clk_i);
            if (compare_out_a_o !== pa)
                tg++;
            pa = compare_out_a_o;
        end
        `CHK("toggle_a", 10, tg)
        `CHK("phase_b_top", 1'b1, compare_out_b_o)
        wb(1'b0, ris, 8'h00, rv);
        `CHK("phase_ovf", 1'b1, rv[0])
        $display("end phase top");
        conclude();
    end
endmodule
